// ===== design/amt_axis_timer.v
`timescale 1ns/1ps
`include "amt_timer_regs.vh"

module amt_axis_timer (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Host register writes
  input wire cmd_wr,
  input wire [7:0] command_register,
  input wire [15:0] data_low_register,
  input wire [15:0] data_high_register,
  input wire [15:0] mode_register,
  input wire [15:0] interrupt_enable_register,
  // Synchronous-action requests
  input wire sync_start,
  input wire sync_stop,
  input wire sync_save,
  // Readback
  output reg [15:0] read_data_low_q,
  output reg [15:0] read_data_high_q,
  output reg read_valid_q,
  output reg [15:0] axis_status_register_q,
  // Saved count for the compare register
  output reg [30:0] save_value_q,
  output reg save_valid_q,
  // Events
  output reg expiry_event_q,
  output reg timer_irq_q
);

  // ----------------------------------------
  // Command strobes and tick
  // ----------------------------------------
  wire set_limit;
  wire read_count;
  wire cmd_start;
  wire cmd_stop;
  wire tick;
  reg run_q;
  reg [30:0] current_count_value_q;
  reg [30:0] limit_q;
  reg [30:0] data_q;
  wire start_req;
  wire stop_req;
  wire expire;
  wire repeat_mode;

  amt_cmd_decode u_dec (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .cmd_wr(cmd_wr),
    .command_register(command_register),
    .set_limit_q(set_limit),
    .read_count_q(read_count),
    .start_q(cmd_start),
    .stop_q(cmd_stop)
  );

  // ----------------------------------------
  // Start and stop requests
  // ----------------------------------------
  // Host commands and synchronous actions share one path,
  // so both obey the same stop-over-start priority below
  assign start_req = cmd_start | sync_start;
  assign stop_req = cmd_stop | sync_stop;

  // ----------------------------------------
  // Microsecond tick
  // ----------------------------------------
  // Start restarts the divider so each microsecond is full length;
  // the price is that a start while running drops the partial microsecond
  amt_prescaler u_pre (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(run_q),
    .restart(start_req),
    .tick_q(tick)
  );

  // ----------------------------------------
  // Mode and expiry detect
  // ----------------------------------------
  wire [30:0] count_plus_one;
  wire limit_hit;

  // Mode is a level, read afresh at every expiry
  assign repeat_mode = mode_register[`AMT_MODE_REPEAT_BIT];
  // Shared by the limit compare and the increment
  assign count_plus_one = current_count_value_q + 31'h00000001;
  // Equality, not greater-or-equal: a limit lowered below the count runs on to wrap
  assign limit_hit = (count_plus_one == limit_q);
  // Judged on the tick that would bring the count to the limit,
  // so the count shows zero afterwards and never the limit itself
  assign expire = run_q && tick && limit_hit;

  // ----------------------------------------
  // Limit register
  // ----------------------------------------
  reg [30:0] data_d;
  reg [30:0] limit_d;

  // Data is sampled at the write so the strobe delay cannot pick up newer data
  always @* begin
    data_d = data_q;
    if (cmd_wr) begin
      data_d = {data_high_register[14:0], data_low_register};
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      data_q <= `AMT_LIMIT_RST;
    end else begin
      data_q <= data_d;
    end
  end

  // A new limit takes effect at once, even in mid-count
  always @* begin
    limit_d = limit_q;
    if (set_limit) begin
      limit_d = data_q;
    end
  end

  // Out of reset the limit is the largest legal value
  always @(posedge sys_clk) begin
    if (!rstn) begin
      limit_q <= `AMT_LIMIT_RST;
    end else begin
      limit_q <= limit_d;
    end
  end

  // ----------------------------------------
  // Counter and run state
  // ----------------------------------------
  reg run_d;
  reg [30:0] count_d;

  // Stop wins over a coincident start, and both win over expiry,
  // so a stop landing on the expiry tick still clears the count;
  // a limit of zero only matches once the count wraps
  always @* begin
    run_d = run_q;
    count_d = current_count_value_q;
    if (stop_req) begin
      run_d = 1'b0;
      count_d = `AMT_COUNT_RST;
    end else if (start_req) begin
      run_d = 1'b1;
      count_d = `AMT_COUNT_RST;
    end else if (expire) begin
      count_d = `AMT_COUNT_RST;
      if (repeat_mode) begin
        run_d = 1'b1;
      end else begin
        run_d = 1'b0;
      end
    end else if (run_q && tick) begin
      count_d = count_plus_one;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      run_q <= 1'b0;
      current_count_value_q <= `AMT_COUNT_RST;
    end else begin
      run_q <= run_d;
      current_count_value_q <= count_d;
    end
  end

  // ----------------------------------------
  // Expiry event
  // ----------------------------------------
  // Trigger for the synchronous-action engine, one cycle per expiry;
  // the count is already zero when this pulse shows
  always @(posedge sys_clk) begin
    if (!rstn) begin
      expiry_event_q <= 1'b0;
    end else begin
      expiry_event_q <= expire;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  wire irq_enable;

  assign irq_enable = interrupt_enable_register[`AMT_IEN_TIMER_BIT];

  // Pulse only; latching and clearing belong to the interrupt aggregator.
  // The enable is a level read at the expiry itself
  always @(posedge sys_clk) begin
    if (!rstn) begin
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= expire && irq_enable;
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  wire [15:0] status_d;
  genvar sb;

  // Only the running bit is owned here; the other bits read zero
  generate
    for (sb = 0; sb < 16; sb = sb + 1) begin : g_status
      if (sb == `AMT_STAT_RUN_BIT) begin : g_run
        assign status_d[sb] = run_q;
      end else begin : g_zero
        assign status_d[sb] = 1'b0;
      end
    end
  endgenerate

  // Registered, so the bit follows the run state one cycle later
  always @(posedge sys_clk) begin
    if (!rstn) begin
      axis_status_register_q <= 16'h0000;
    end else begin
      axis_status_register_q <= status_d;
    end
  end

  // ----------------------------------------
  // Count readback
  // ----------------------------------------
  reg [15:0] read_low_d;
  reg [15:0] read_high_d;

  // Both halves come from one edge, so a count that ticks between the
  // host's two fetches cannot tear the value
  always @* begin
    read_low_d = read_data_low_q;
    read_high_d = read_data_high_q;
    if (read_count) begin
      read_low_d = current_count_value_q[15:0];
      read_high_d = {1'b0, current_count_value_q[30:16]};
    end
  end

  // Valid marks the one cycle in which a fresh value first stands
  always @(posedge sys_clk) begin
    if (!rstn) begin
      read_data_low_q <= 16'h0000;
      read_data_high_q <= 16'h0000;
      read_valid_q <= 1'b0;
    end else begin
      read_data_low_q <= read_low_d;
      read_data_high_q <= read_high_d;
      read_valid_q <= read_count;
    end
  end

  // ----------------------------------------
  // Saved count
  // ----------------------------------------
  reg [30:0] save_d;

  // The compare register itself lives outside; this only hands the value over
  always @* begin
    save_d = save_value_q;
    if (sync_save) begin
      save_d = current_count_value_q;
    end
  end

  // The value holds until the next save request
  always @(posedge sys_clk) begin
    if (!rstn) begin
      save_value_q <= `AMT_COUNT_RST;
      save_valid_q <= 1'b0;
    end else begin
      save_value_q <= save_d;
      save_valid_q <= sync_save;
    end
  end

endmodule

// ===== design/amt_timer_regs.vh
`ifndef AMT_TIMER_REGS_VH
`define AMT_TIMER_REGS_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define AMT_CMD_SET_LIMIT 8'h16
`define AMT_CMD_READ_COUNT 8'h38
`define AMT_CMD_START 8'h73
`define AMT_CMD_STOP 8'h74

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AMT_MODE_REPEAT_BIT 14
`define AMT_IEN_TIMER_BIT 9
`define AMT_STAT_RUN_BIT 10

// ----------------------------------------
// Timing
// ----------------------------------------
`define AMT_CLK_MHZ 16
`define AMT_TICK_NS 1000
`define AMT_CLK_PERIOD_NS 4
`define AMT_TICK_CYCLES (`AMT_TICK_NS / `AMT_CLK_PERIOD_NS)
`define AMT_PRESCALE_W 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AMT_COUNT_RST 31'h00000000
`define AMT_LIMIT_RST 31'h7FFFFFFF

`endif

// ===== design/amt_prescaler.v
`timescale 1ns/1ps
`include "amt_timer_regs.vh"

// Emits a one-cycle tick every microsecond while enabled
module amt_prescaler (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Control
  input wire run,
  input wire restart,
  // Tick
  output reg tick_q
);

  reg [`AMT_PRESCALE_W-1:0] cnt_q;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // Restart realigns phase so the first microsecond is whole
  always @(posedge sys_clk) begin
    if (!rstn || !run || restart) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q == `AMT_TICK_CYCLES - 1) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

endmodule

// ===== design/amt_cmd_decode.v
`timescale 1ns/1ps
`include "amt_timer_regs.vh"

// Turns a command-register write into one-cycle strobes
module amt_cmd_decode (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Command write
  input wire cmd_wr,
  input wire [7:0] command_register,
  // Strobes
  output reg set_limit_q,
  output reg read_count_q,
  output reg start_q,
  output reg stop_q
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rstn) begin
      set_limit_q <= 1'b0;
      read_count_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      set_limit_q <= cmd_wr && (command_register == `AMT_CMD_SET_LIMIT);
      read_count_q <= cmd_wr && (command_register == `AMT_CMD_READ_COUNT);
      start_q <= cmd_wr && (command_register == `AMT_CMD_START);
      stop_q <= cmd_wr && (command_register == `AMT_CMD_STOP);
    end
  end

endmodule

// ===== testbench/amt_timer_sva.sv
`timescale 1ns/1ps
module amt_timer_sva (
  input wire sys_clk, rstn, cmd_wr, sync_start, sync_stop, sync_save,
  input wire read_valid_q, save_valid_q, expiry_event_q, timer_irq_q,
  input wire [7:0] command_register,
  input wire [15:0] mode_register, interrupt_enable_register, axis_status_register_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_cmd(c);
    cmd_wr && command_register == c;
  endsequence
  a_read_answer: assert property (s_cmd(8'h38) |=> ##1 read_valid_q) else $error("no read");
  a_read_cause: assert property (
    read_valid_q |-> $past(cmd_wr, 2) && $past(command_register, 2) == 8'h38) else $error("stray read");
  a_start_cmd: assert property (s_cmd(8'h73) |=> ##2 axis_status_register_q[10]) else $error("no start");
  a_stop_cmd: assert property (s_cmd(8'h74) |=> ##2 !axis_status_register_q[10]) else $error("no stop");
  a_sync_start: assert property (sync_start && !sync_stop |=> ##1 axis_status_register_q[10]) else $error("no start");
  a_sync_stop: assert property (sync_stop |=> ##1 !axis_status_register_q[10]) else $error("no stop");
  a_irq_gate: assert property (
    timer_irq_q == (expiry_event_q && $past(interrupt_enable_register[9]))) else $error("bad irq");
  a_mode_end: assert property (
    expiry_event_q |=> axis_status_register_q[10] == $past(mode_register[14], 2)) else $error("bad end");
  a_save_answer: assert property (sync_save |=> save_valid_q) else $error("no save");
  a_event_pulse: assert property (expiry_event_q |=> !expiry_event_q) else $error("long event");
endmodule
bind amt_axis_timer amt_timer_sva u_chk (.sys_clk(sys_clk), .rstn(rstn), .cmd_wr(cmd_wr),
  .sync_start(sync_start), .sync_stop(sync_stop), .sync_save(sync_save), .read_valid_q(read_valid_q),
  .save_valid_q(save_valid_q), .expiry_event_q(expiry_event_q), .timer_irq_q(timer_irq_q),
  .command_register(command_register), .mode_register(mode_register),
  .interrupt_enable_register(interrupt_enable_register), .axis_status_register_q(axis_status_register_q));

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg cmd_wr = 1'b0;
  reg [7:0] code = 8'h00;
  reg [30:0] lim = 31'h00000000;
  reg [15:0] mode = 16'h0000;
  reg [15:0] ien = 16'h0200;
  reg [2:0] sa = 3'h0;
  wire [15:0] rlo, rhi, st;
  wire [30:0] sv;
  wire rv, svv, ev, irq;
  integer miscompares = 0;
  integer checks = 0;
  integer n;
  amt_axis_timer u_amt_axis_timer (.sys_clk(sys_clk), .rstn(rstn), .cmd_wr(cmd_wr), .command_register(code),
    .data_low_register(lim[15:0]), .data_high_register({1'b0, lim[30:16]}), .mode_register(mode),
    .interrupt_enable_register(ien), .sync_start(sa[0]), .sync_stop(sa[1]), .sync_save(sa[2]),
    .read_data_low_q(rlo), .read_data_high_q(rhi), .read_valid_q(rv), .axis_status_register_q(st),
    .save_value_q(sv), .save_valid_q(svv), .expiry_event_q(ev), .timer_irq_q(irq));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    begin
      if (miscompares == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tk(input integer k);
    begin
      repeat (k) @(negedge sys_clk);
    end
  endtask
  task send(input [7:0] c, input [30:0] l);
    begin
      @(negedge sys_clk);
      code = c;
      lim = l;
      cmd_wr = 1'b1;
      @(negedge sys_clk);
      cmd_wr = 1'b0;
    end
  endtask
  task sy(input [2:0] m);
    begin
      @(negedge sys_clk);
      sa = m;
      @(negedge sys_clk);
      sa = 3'h0;
    end
  endtask
  task rd(input [30:0] e);
    begin
      send(8'h38, lim);
      tk(1);
      chk({rv, rhi, rlo}, {2'h2, e});
    end
  endtask
  // Bounded wait for the next expiry; returns cycles waited
  task wexp(output integer c);
    begin
      c = 0;
      while (ev !== 1'b1) begin
        @(negedge sys_clk);
        c = c + 1;
        if (c > 3000) begin
          miscompares = miscompares + 1;
          report_and_stop;
        end
      end
      chk(irq, ien[9]);
      @(negedge sys_clk);
    end
  endtask
  task t_single;
    begin
      send(8'h16, 31'h00000002);
      send(8'h73, lim);
      tk(3);
      chk(st, 16'h0400);
      wexp(n);
      chk(n > 494 && n < 510, 1);
      chk(st[10], 0);
      rd(31'h00000000);
    end
  endtask
  task t_repeat;
    begin
      mode = 16'h4000;
      ien = 16'h0000;
      send(8'h16, 31'h00000001);
      send(8'h73, lim);
      wexp(n);
      wexp(n);
      chk(n, 249);
      chk(st[10], 1);
      send(8'h16, 31'h00000003);
      wexp(n);
      chk(n > 740 && n < 750, 1);
      tk(300);
      rd(31'h00000001);
      sy(3'h4);
      chk({svv, sv}, 32'h80000001);
      sy(3'h2);
      tk(2);
      chk(st[10], 0);
      rd(31'h00000000);
      sy(3'h1);
      tk(2);
      chk(st[10], 1);
      send(8'h74, lim);
      tk(3);
      chk(st[10], 0);
    end
  endtask
  initial begin
    tk(5);
    rstn = 1'b1;
    t_single;
    t_repeat;
    report_and_stop;
  end
endmodule
